// File: design/cpu_interrupt_sequencer.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "irq_seq_map.svh"
// How it works
// - Each source own vector, lower address wins
// - Reset first, external request zero next
// - Take only with source and global enable
// - Lock bits suppress interrupts by PC region
// - Relocate bit and fuse move vectors
// - Entry clears global enable
// - Return sets global enable again
// - Hardware clears flag when vectoring
// - Write one clears flag, zero ignored
// - Flags stay latched while disabled
// - Latched flags serviced in priority order
// - Level sources request only while present
// - One main instruction after return first
// - Global disable acts in same cycle
// - Instruction after enable completes first
// - Entry four cycles, pushes program counter
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds four cycles
// - Return four cycles, pops two bytes
// - Push decrements, pop increments pointer by two
module cpu_interrupt_sequencer
  import irq_seq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  src_event,
  input  wire logic [7:0]  src_level,
  input  wire logic        instr_done,
  input  wire logic        op_return_from_irq_instr,
  input  wire logic        op_sei,
  input  wire logic        op_cli,
  input  wire logic        core_sleeping,
  input  wire logic        wake_ready,
  input  wire logic [13:0] pc_now,
  input  wire logic        app_section_lock_bit,
  input  wire logic        boot_section_lock_bit,
  input  wire logic        boot_reset_vector_fuse,
  input  wire logic [7:0]  stack_rdata,
  output logic             core_hold,
  output logic             pc_load,
  output logic      [13:0] pc_value,
  output logic             irq_taken,
  output logic             stack_we,
  output logic             stack_re,
  output logic      [11:0] stack_addr,
  output logic      [7:0]  stack_wdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lowest set bit wins
  function automatic logic [2:0] first_set(input src_vec_t v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Vector slot to program address
  function automatic pc_t vec_addr(input logic relocate, input logic [3:0] slot);
    pc_t base;
    base = relocate ? `BOOT_START : 14'h0000;
    return base + 14'({10'h000, slot}) * `VECTOR_STRIDE;
  endfunction : vec_addr

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [7:0]  core_control_register;
  logic [7:0]  status_register;
  src_vec_t    src_enable;
  src_vec_t    src_flag;
  src_vec_t    flag_type;
  logic [11:0] stack_ptr;
  seq_state_t  state;
  seq_state_t  next_state;
  logic [2:0]  wait_cnt;
  logic [2:0]  taken_idx;
  pc_t         ret_pc;
  logic [5:0]  ret_hi;

  logic        wr_req;
  logic        rd_req;
  logic        relocate;
  logic        global_en;
  src_vec_t    request;
  src_vec_t    armed;
  logic        in_boot;
  logic        locked;
  logic        boundary;
  logic        take;
  logic        wake;
  logic        ret_start;
  logic [2:0]  win_idx;

  assign wr_req   = psel & penable & pready & pwrite;
  assign rd_req   = psel & penable & ~pready;
  assign relocate = core_control_register[`POS_RELOCATE];
  assign global_en = status_register[`POS_GLOBAL_EN];

  // Arbitration among pending enabled sources
  assign request  = (src_flag & flag_type) | (src_level & ~flag_type);
  assign armed    = request & src_enable;
  assign win_idx  = first_set(armed);
  assign in_boot  = pc_now >= `BOOT_START;
  assign locked   = (app_section_lock_bit & ~in_boot & relocate)
                  | (boot_section_lock_bit & in_boot & ~relocate);
  assign boundary = instr_done & (state == S_IDLE) & ~core_sleeping;
  // Disable and enable instructions gate the same boundary
  assign take     = boundary & global_en & ~op_cli & ~op_sei & ~op_return_from_irq_instr
                  & (|armed) & ~locked;
  assign wake     = core_sleeping & wake_ready & (state == S_IDLE) & global_en
                  & (|armed) & ~locked;
  assign ret_start = boundary & op_return_from_irq_instr;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // One wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_req;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (rd_req) begin
        unique case (paddr)
          `OFS_CORE_CTRL: prdata <= {24'h000000, core_control_register};
          `OFS_STATUS:    prdata <= {24'h000000, status_register};
          `OFS_ENABLE:    prdata <= {24'h000000, src_enable};
          `OFS_FLAGS:     prdata <= {24'h000000, src_flag};
          `OFS_TYPE:      prdata <= {24'h000000, flag_type};
          `OFS_STACK_PTR: prdata <= {20'h00000, stack_ptr};
          `OFS_STATE:     prdata <= {8'h00, src_level, 5'h00, taken_idx, 4'h0, state};
          default:        pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_control_register <= `RST_CORE_CTRL;
      src_enable            <= `RST_ENABLE;
      flag_type             <= `RST_TYPE;
    end else if (wr_req) begin
      if (paddr == `OFS_CORE_CTRL) begin
        core_control_register <= pwdata[7:0];
      end
      if (paddr == `OFS_ENABLE) begin
        src_enable <= pwdata[7:0];
      end
      if (paddr == `OFS_TYPE) begin
        flag_type <= pwdata[7:0];
      end
    end
  end

  // Global enable: entry clears, return and enable set, disable clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_register <= `RST_STATUS;
    end else begin
      if (wr_req && paddr == `OFS_STATUS) begin
        status_register <= pwdata[7:0];
      end
      if (boundary && op_cli) begin
        status_register[`POS_GLOBAL_EN] <= 1'b0;
      end
      if (boundary && op_sei) begin
        status_register[`POS_GLOBAL_EN] <= 1'b1;
      end
      if (take || wake) begin
        status_register[`POS_GLOBAL_EN] <= 1'b0;
      end
      if (state == S_RET4) begin
        status_register[`POS_GLOBAL_EN] <= 1'b1;
      end
    end
  end

  // Pending flags: set wins over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_flag <= 8'h00;
    end else begin
      src_flag <= (src_flag
                   & ~((wr_req && paddr == `OFS_FLAGS) ? pwdata[7:0] : 8'h00)
                   & ~(((take || wake) ? (8'h01 << win_idx) : 8'h00) & flag_type))
                  | (src_event & flag_type);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry and return sequencer

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (wake) begin
          next_state = S_WAKE;
        end else if (take) begin
          next_state = S_PUSH_LO;
        end else if (ret_start) begin
          next_state = S_POP_HI;
        end
      end
      S_WAKE:    next_state = (wait_cnt == `WAKE_CYCLES - 3'h1) ? S_PUSH_LO : S_WAKE;
      S_PUSH_LO: next_state = S_PUSH_HI;
      S_PUSH_HI: next_state = S_ENT3;
      S_ENT3:    next_state = S_ENT4;
      S_ENT4:    next_state = S_IDLE;
      S_POP_HI:  next_state = S_POP_LO;
      S_POP_LO:  next_state = S_RET3;
      S_RET3:    next_state = S_RET4;
      S_RET4:    next_state = S_IDLE;
      S_RESET:   next_state = S_IDLE;
      default:   next_state = S_IDLE;
    endcase
  end

  // State, wake count and captured source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_RESET;
      wait_cnt  <= 3'h0;
      taken_idx <= 3'h0;
      ret_pc    <= 14'h0000;
    end else begin
      state    <= next_state;
      wait_cnt <= (state == S_WAKE) ? wait_cnt + 3'h1 : 3'h0;
      if (take || wake) begin
        taken_idx <= win_idx;
        ret_pc    <= pc_now;
      end
    end
  end

  // Stack pointer: push minus two, pop plus two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr <= `RST_STACK_PTR;
    end else if (next_state == S_PUSH_LO || next_state == S_PUSH_HI) begin
      stack_ptr <= stack_ptr - 12'h001;
    end else if (next_state == S_POP_HI || next_state == S_POP_LO) begin
      stack_ptr <= stack_ptr + 12'h001;
    end else if (wr_req && paddr == `OFS_STACK_PTR) begin
      stack_ptr <= pwdata[11:0];
    end
  end

  // Stack memory strobes, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_we    <= 1'b0;
      stack_re    <= 1'b0;
      stack_addr  <= 12'h000;
      stack_wdata <= 8'h00;
      ret_hi      <= 6'h00;
    end else begin
      stack_we <= (next_state == S_PUSH_LO) || (next_state == S_PUSH_HI);
      stack_re <= (next_state == S_POP_HI) || (next_state == S_POP_LO);
      if (next_state == S_PUSH_LO) begin
        stack_addr  <= stack_ptr;
        stack_wdata <= (state == S_WAKE) ? ret_pc[7:0] : pc_now[7:0];
      end else if (next_state == S_PUSH_HI) begin
        stack_addr  <= stack_ptr;
        stack_wdata <= {2'b00, ret_pc[13:8]};
      end else if (next_state == S_POP_HI || next_state == S_POP_LO) begin
        stack_addr <= stack_ptr + 12'h001;
      end
      if (state == S_POP_LO) begin
        ret_hi <= stack_rdata[5:0];
      end
    end
  end

  // Core handshake: hold, vector load, acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_hold <= 1'b1;
      pc_load   <= 1'b0;
      pc_value  <= 14'h0000;
      irq_taken <= 1'b0;
    end else begin
      core_hold <= next_state != S_IDLE;
      irq_taken <= take || wake;
      pc_load   <= 1'b0;
      if (state == S_RESET) begin
        pc_load  <= 1'b1;
        pc_value <= boot_reset_vector_fuse ? `BOOT_START : 14'h0000;
      end else if (state == S_ENT3) begin
        pc_load  <= 1'b1;
        pc_value <= vec_addr(relocate, {1'b0, taken_idx} + 4'h1);
      end else if (state == S_RET3) begin
        pc_load  <= 1'b1;
        pc_value <= {ret_hi, stack_rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_entry_len;
    @(posedge pclk) disable iff (!presetn)
      take |=> state == S_PUSH_LO ##1 state == S_PUSH_HI ##1 state == S_ENT3
      ##1 (state == S_ENT4 && pc_load);
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry not four cycles");

  property p_wake_len;
    @(posedge pclk) disable iff (!presetn)
      wake |=> (state == S_WAKE) [*4] ##1 state == S_PUSH_LO;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake delay wrong");

  property p_ret_len;
    @(posedge pclk) disable iff (!presetn)
      ret_start |=> stack_re [*2] ##2 pc_load ##1 global_en;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return not four cycles");

  property p_entry_clears_ie;
    @(posedge pclk) disable iff (!presetn)
      (take || wake) |=> !global_en;
  endproperty
  a_entry_clears_ie: assert property (p_entry_clears_ie) else $error("ie kept on entry");

  property p_cli_blocks;
    @(posedge pclk) disable iff (!presetn)
      (boundary && op_cli) |-> !take ##1 !global_en;
  endproperty
  a_cli_blocks: assert property (p_cli_blocks) else $error("take after disable");

  property p_sei_defers;
    @(posedge pclk) disable iff (!presetn)
      (boundary && op_sei) |=> !irq_taken;
  endproperty
  a_sei_defers: assert property (p_sei_defers) else $error("take after enable");

  property p_enable_needed;
    @(posedge pclk) disable iff (!presetn)
      irq_taken |-> $past(global_en) && src_enable[taken_idx];
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("disabled source taken");

  property p_sp_push;
    @(posedge pclk) disable iff (!presetn)
      take |-> ##3 stack_ptr == $past(stack_ptr, 3) - 12'h002;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("push pointer wrong");

  property p_flag_cleared;
    @(posedge pclk) disable iff (!presetn)
      (take && flag_type[win_idx] && !src_event[win_idx]) |=> !src_flag[taken_idx];
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("flag not cleared");

  property p_priority;
    @(posedge pclk) disable iff (!presetn)
      take |-> (armed & ((8'h01 << win_idx) - 8'h01)) == 8'h00;
  endproperty
  a_priority: assert property (p_priority) else $error("lower vector skipped");

  c_take:   cover property (@(posedge pclk) disable iff (!presetn) take);
  c_wake:   cover property (@(posedge pclk) disable iff (!presetn) wake);
  c_return: cover property (@(posedge pclk) disable iff (!presetn) ret_start);
  c_nested: cover property (@(posedge pclk) disable iff (!presetn)
                            (src_flag & src_enable) == 8'h03 ##1 take);

endmodule : cpu_interrupt_sequencer

// File: pkg/irq_seq_map.svh
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH

// Register byte offsets
`define OFS_CORE_CTRL    8'h00
`define OFS_STATUS       8'h04
`define OFS_ENABLE       8'h08
`define OFS_FLAGS        8'h0C
`define OFS_TYPE         8'h10
`define OFS_STACK_PTR    8'h14
`define OFS_STATE        8'h18

// Field positions
`define POS_RELOCATE     0
`define POS_GLOBAL_EN    7

// Reset values
`define RST_CORE_CTRL    8'h00
`define RST_STATUS       8'h00
`define RST_ENABLE       8'h00
`define RST_TYPE         8'hFF
`define RST_STACK_PTR    12'h4FF

// Program memory layout
`define BOOT_START       14'h3800
`define VECTOR_STRIDE    14'h0002

// Timing counts in clock cycles
`define ENTRY_CYCLES     3'h4
`define WAKE_CYCLES      3'h4
`define RETURN_CYCLES    3'h4

`endif

// File: pkg/irq_seq_pkg.sv
package irq_seq_pkg;

  // Sequencer states, Gray along entry and return paths except the steps back to S_IDLE and S_WAKE to S_PUSH_LO
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_PUSH_LO = 4'h1,
    S_PUSH_HI = 4'h3,
    S_ENT3    = 4'h2,
    S_ENT4    = 4'h6,
    S_POP_HI  = 4'h4,
    S_POP_LO  = 4'h5,
    S_RET3    = 4'h7,
    S_RET4    = 4'hF,
    S_WAKE    = 4'h8,
    S_RESET   = 4'hC
  } seq_state_t;

  typedef logic [7:0]  src_vec_t;
  typedef logic [13:0] pc_t;

endpackage : irq_seq_pkg

// File: bench/stack_sram_model.sv
`timescale 1ns/100ps
module stack_sram_model (
  input  wire logic        pclk,
  input  wire logic        stack_we,
  input  wire logic        stack_re,
  input  wire logic [11:0] stack_addr,
  input  wire logic [7:0]  stack_wdata,
  output logic      [7:0]  stack_rdata
);
  logic [7:0] mem [0:4095];

  // Byte store; read data valid only the cycle after a read strobe
  always @(posedge pclk) begin
    if (stack_we) mem[stack_addr] <= stack_wdata;
    // Only return addresses land here, never the status byte
    if (stack_re) stack_rdata <= mem[stack_addr];
    else stack_rdata <= ~stack_rdata; // Stale data scrambled
  end
endmodule : stack_sram_model

// File: bench/test_cpu_interrupt_sequencer.sv
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module test_cpu_interrupt_sequencer;
  import irq_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, src_event, src_level, stack_rdata, stack_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic instr_done, op_return_from_irq_instr, op_sei, op_cli, core_hold, pc_load, irq_taken;
  logic stack_we, stack_re;
  logic [13:0] pc_now, pc_value;
  logic [11:0] stack_addr;
  logic sleeping  = 1'b0;
  logic wake_rdy  = 1'b0;
  logic app_lock  = 1'b0;
  logic boot_lock = 1'b0;
  logic rst_fuse  = 1'b0;
  int n_fail, tests_run, cyc, n, k;

  cpu_interrupt_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .src_level(src_level),
    .instr_done(instr_done), .op_return_from_irq_instr(op_return_from_irq_instr), .op_sei(op_sei), .op_cli(op_cli),
    .core_sleeping(sleeping), .wake_ready(wake_rdy), .pc_now(pc_now),
    .app_section_lock_bit(app_lock), .boot_section_lock_bit(boot_lock),
    .boot_reset_vector_fuse(rst_fuse),
    .stack_rdata(stack_rdata), .core_hold(core_hold), .pc_load(pc_load),
    .pc_value(pc_value), .irq_taken(irq_taken), .stack_we(stack_we), .stack_re(stack_re),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata));
  stack_sram_model u_mem (.pclk(pclk), .stack_we(stack_we), .stack_re(stack_re),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail = n_fail + 1;
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, a > 8'h18}, {31'h0, pslverr});
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rchk
  // Instruction boundary, optionally qualified by return_from_irq_instr, sei or cli
  task bnd(input logic r, input logic s, input logic c);
    @(posedge pclk);
    instr_done <= 1'b1; op_return_from_irq_instr <= r; op_sei <= s; op_cli <= c;
    @(posedge pclk);
    instr_done <= 1'b0; op_return_from_irq_instr <= 1'b0; op_sei <= 1'b0; op_cli <= 1'b0;
  endtask : bnd
  // Edges until one samples pc_load high, 0 if none in 8; k for irq_taken
  task wait_load();
    n = 0;
    k = 0;
    for (int i = 1; i <= 8 && n == 0; i++) begin
      @(negedge pclk);
      if (pc_load === 1'b1) n = i;
      if (irq_taken === 1'b1) k = i;
    end
  endtask : wait_load
  task evt(input logic [7:0] v);
    @(posedge pclk);
    src_event <= v;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask : evt
  task take(input logic r, input logic [13:0] vec);
    bnd(r, 1'b0, 1'b0);
    wait_load();
    chk("latency", 4, n);
    chk("pc_value", {18'h0, vec}, {18'h0, pc_value});
    chk("core_hold", 1, core_hold);
    chk("irq_taken", {31'h0, ~r}, k);
  endtask : take

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset(input logic fuse);
    @(posedge pclk);
    presetn <= 1'b0;
    rst_fuse <= fuse;
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    wait_load();
    chk("reset vector delay", 2, n);
    chk("reset vector", {18'h0, fuse ? `BOOT_START : 14'h0000}, {18'h0, pc_value});
    chk("core_hold after reset", 0, core_hold);
    rchk("status", `OFS_STATUS, 32'h0);
    rchk("type", `OFS_TYPE, 32'hFF);
    rchk("sp", `OFS_STACK_PTR, 32'h4FF);
    rchk("unmapped", 8'h40, 32'h0);
  endtask : t_reset
  task t_entry_return();
    evt(8'h24);
    rchk("latched flags", `OFS_FLAGS, 32'h24);
    apb(1'b1, `OFS_FLAGS, 32'h0);
    rchk("flags after zero", `OFS_FLAGS, 32'h24);
    apb(1'b1, `OFS_ENABLE, 32'h24);
    apb(1'b1, `OFS_STATUS, 32'h80);
    pc_now <= 14'h1234;
    take(1'b0, 14'h0006);
    chk("push lo", 32'h34, {24'h0, u_mem.mem[12'h4FF]});
    chk("push hi", 32'h12, {24'h0, u_mem.mem[12'h4FE]});
    rchk("sp pushed", `OFS_STACK_PTR, 32'h4FD);
    rchk("ie cleared", `OFS_STATUS, 32'h0);
    rchk("hw flag clear", `OFS_FLAGS, 32'h20);
    take(1'b1, 14'h1234);
    rchk("ie set", `OFS_STATUS, 32'h80);
    rchk("sp popped", `OFS_STACK_PTR, 32'h4FF);
    take(1'b0, 14'h000C);
    take(1'b1, 14'h1234);
  endtask : t_entry_return
  task t_cli_sei();
    apb(1'b1, `OFS_ENABLE, 32'h01);
    evt(8'h01);
    bnd(1'b0, 1'b0, 1'b1);
    wait_load();
    chk("no take on cli", 0, n);
    apb(1'b1, `OFS_STATUS, 32'h80);
    bnd(1'b0, 1'b1, 1'b0);
    wait_load();
    chk("no take on sei", 0, n);
    take(1'b0, 14'h0002);
    evt(8'h08);
    rchk("flag off source", `OFS_FLAGS, 32'h08);
    apb(1'b1, `OFS_FLAGS, 32'h08);
    rchk("flag w1c", `OFS_FLAGS, 32'h0);
  endtask : t_cli_sei
  // Level sources, lock regions, relocation and wake from sleep
  task t_level_lock_wake();
    apb(1'b1, `OFS_TYPE, 32'h00);
    apb(1'b1, `OFS_ENABLE, 32'h00);
    apb(1'b1, `OFS_STATUS, 32'h80);
    @(posedge pclk);
    src_level <= 8'h02;
    @(posedge pclk);
    src_level <= 8'h00;
    apb(1'b1, `OFS_ENABLE, 32'h02);
    bnd(1'b0, 1'b0, 1'b0);
    wait_load();
    chk("vanished level", 0, n);
    rchk("level never latched", `OFS_FLAGS, 32'h0);
    @(posedge pclk);
    src_level <= 8'h02;
    wait_load();
    chk("no boundary", 0, n);
    take(1'b0, 14'h0004);
    apb(1'b1, `OFS_CORE_CTRL, 32'h01);
    apb(1'b1, `OFS_STATUS, 32'h80);
    @(posedge pclk);
    app_lock <= 1'b1;
    bnd(1'b0, 1'b0, 1'b0);
    wait_load();
    chk("app lock", 0, n);
    @(posedge pclk);
    app_lock <= 1'b0;
    take(1'b0, 14'h3804);
    apb(1'b1, `OFS_CORE_CTRL, 32'h00);
    apb(1'b1, `OFS_STATUS, 32'h80);
    @(posedge pclk);
    pc_now <= 14'h3900;
    boot_lock <= 1'b1;
    bnd(1'b0, 1'b0, 1'b0);
    wait_load();
    chk("boot lock", 0, n);
    @(posedge pclk);
    boot_lock <= 1'b0;
    sleeping <= 1'b1;
    wait_load();
    chk("sleep start-up", 0, n);
    @(posedge pclk);
    wake_rdy <= 1'b1;
    @(posedge pclk);
    sleeping <= 1'b0;
    wake_rdy <= 1'b0;
    wait_load();
    chk("wake latency", 8, n);
    chk("wake vector", 32'h0004, {18'h0, pc_value});
    chk("wake irq_taken", 1, k);
    @(posedge pclk);
    src_level <= 8'h00;
  endtask : t_level_lock_wake

  task stop_test();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    presetn = 1'b0;
    n_fail = 0; tests_run = 0; cyc = 0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    src_event = 8'h00; src_level = 8'h00; instr_done = 1'b0; op_return_from_irq_instr = 1'b0;
    op_sei = 1'b0; op_cli = 1'b0; pc_now = 14'h0000;
    t_reset(1'b0);
    t_entry_return();
    t_cli_sei();
    t_level_lock_wake();
    t_reset(1'b1);
    stop_test();
  end
endmodule : test_cpu_interrupt_sequencer
